/* File: bbr_pkg.sv */
// Package for the single-bit alias remapper: window map, sizes, states.
// Assumes a 32-bit byte-addressed system bus on one clock.
package bbr_pkg;

	// ==========================================================
	// Window map
	localparam logic [31:0] BBR_SRAM_BIT_BASE   = 32'h2000_0000;
	localparam logic [31:0] BBR_SRAM_ALIAS_BASE = 32'h2200_0000;
	localparam logic [31:0] BBR_PERI_BIT_BASE   = 32'h4000_0000;
	localparam logic [31:0] BBR_PERI_ALIAS_BASE = 32'h4200_0000;
	localparam logic [31:0] BBR_BIT_WIN_SIZE    = 32'h0010_0000;
	localparam logic [31:0] BBR_ALIAS_WIN_SIZE  = 32'h0200_0000;

	// ==========================================================
	// Field positions inside an alias offset
	localparam int BBR_BITNUM_LSB  = 2;
	localparam int BBR_BYTEOFS_LSB = 5;
	localparam int BBR_BYTEOFS_W   = 20;

	// ==========================================================
	// Transfer sizes on the bus
	localparam logic [1:0] BBR_SIZE_BYTE = 2'h0;
	localparam logic [1:0] BBR_SIZE_HALF = 2'h1;
	localparam logic [1:0] BBR_SIZE_WORD = 2'h2;

	// ==========================================================
	// Reset values
	localparam logic [31:0] BBR_ZERO32 = 32'h0000_0000;

	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {
		BBR_IDLE,
		BBR_PASS,
		BBR_RD,
		BBR_WR
	} bbr_state_t;

endpackage

/* File: bbr_decode.sv */
// Alias window decoder: tells whether an address lies in one alias window
// and yields the target byte address and bit number.
// Assumes a purely combinational use by the remapper.
`timescale 1ns/1ps
`default_nettype none
module bbr_decode (
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] alias_base_in,
	input  wire logic [31:0] bit_base_in,
	output logic             hit_out,
	output logic [31:0]      byte_addr_out,
	output logic [2:0]       bit_num_out
);
	import bbr_pkg::*;

	logic [31:0] ofs;

	always_comb begin
		ofs           = addr_in - alias_base_in;
		hit_out       = (addr_in >= alias_base_in) && (ofs < BBR_ALIAS_WIN_SIZE);
		// Offset = byte*32 + bit*4
		bit_num_out   = ofs[BBR_BITNUM_LSB +: 3];
		byte_addr_out = bit_base_in + {12'h000, ofs[BBR_BYTEOFS_LSB +: BBR_BYTEOFS_W]};
	end

endmodule
`default_nettype wire

/* File: bbr_remap.sv */
// Single-bit alias remapper sitting between core and system bus.
// Assumes the core holds its request until accepted (ready) and the bus
// answers one access at a time with bus_done_in; ordinary accesses pass.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Alias feature selectable by a parameter
// - Two 1MB target bit windows
// - Two 32MB alias windows, paired
// - Alias data access uses target byte address
// - Alias offset is byte*32 plus bit*4
// - Bit number 0..7 from word index
// - Alias read returns target bit in LSB
// - Alias read yields only 0x01 or 0x00
// - Alias write is atomic read-modify-write
// - Write data bit 0 sets or clears
// - Write data bits 31..1 ignored
// - Core stalls only on overlapping bus access
// - Direct bit window accesses pass unchanged
// - Instruction fetches never remapped
// - Unaligned alias accesses pass unchanged, at their own size and address
// - No exclusive access in bit windows
module bbr_remap #(
	parameter bit ALIAS_EN = 1'b1
) (
	input  wire logic              clock_in,
	input  wire logic              reset_n_in,
	// Core side
	input  wire logic              core_req_in,
	input  wire logic              core_write_in,
	input  wire logic              core_instr_in,
	input  wire logic              core_unaligned_in,
	input  wire logic              core_excl_in,
	input  wire logic [1:0]        core_size_in,
	input  wire logic [31:0]       core_addr_in,
	input  wire logic [31:0]       core_wdata_in,
	output logic                   core_ready_out,
	output logic                   core_done_out,
	output logic                   core_excl_fail_out,
	output logic [31:0]            core_rdata_out,
	// System bus side
	output logic                   bus_req_out,
	output logic                   bus_write_out,
	output logic                   bus_lock_out,
	output logic [1:0]             bus_size_out,
	output logic [31:0]            bus_addr_out,
	output logic [31:0]            bus_wdata_out,
	input  wire logic              bus_done_in,
	input  wire logic [31:0]       bus_rdata_in
);
	import bbr_pkg::*;

	typedef struct packed {
		bbr_state_t  state;
		logic        req;
		logic        write;
		logic        lock;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        is_alias;
		logic [2:0]  bit_num;
		logic        new_bit;
		logic        done;
		logic        excl_fail;
		logic [31:0] rdata;
	} bbr_regs_t;

	bbr_regs_t r;
	bbr_regs_t next_r;

	logic        sram_hit;
	logic        peri_hit;
	logic [31:0] sram_byte;
	logic [31:0] peri_byte;
	logic [2:0]  sram_bit;
	logic [2:0]  peri_bit;
	logic        alias_op;
	logic        in_bitwin;
	logic [31:0] tgt_byte;
	logic [2:0]  tgt_bit;
	logic [7:0]  rd_byte;
	logic [7:0]  mod_byte;

	// ==========================================================
	// Window decode
	bbr_decode u_sram (
		.addr_in       (core_addr_in),
		.alias_base_in (BBR_SRAM_ALIAS_BASE),
		.bit_base_in   (BBR_SRAM_BIT_BASE),
		.hit_out       (sram_hit),
		.byte_addr_out (sram_byte),
		.bit_num_out   (sram_bit)
	);

	bbr_decode u_peri (
		.addr_in       (core_addr_in),
		.alias_base_in (BBR_PERI_ALIAS_BASE),
		.bit_base_in   (BBR_PERI_BIT_BASE),
		.hit_out       (peri_hit),
		.byte_addr_out (peri_byte),
		.bit_num_out   (peri_bit)
	);

	always_comb begin
		// Only aligned word data accesses get a bit operation
		alias_op  = ALIAS_EN && (sram_hit || peri_hit) && !core_instr_in
			&& !core_unaligned_in && (core_size_in == BBR_SIZE_WORD)
			&& (core_addr_in[1:0] == 2'h0);
		tgt_byte  = sram_hit ? sram_byte : peri_byte;
		tgt_bit   = sram_hit ? sram_bit : peri_bit;
		in_bitwin = ((core_addr_in - BBR_SRAM_BIT_BASE) < BBR_BIT_WIN_SIZE)
			|| ((core_addr_in - BBR_PERI_BIT_BASE) < BBR_BIT_WIN_SIZE);
		rd_byte   = bus_rdata_in[8 * r.addr[1:0] +: 8];
		mod_byte  = rd_byte;
		mod_byte[r.bit_num] = r.new_bit;
	end

	// Ready only while no access is outstanding: a new access waits
	assign core_ready_out = (r.state == BBR_IDLE);

	// ==========================================================
	// Transfer sequencer
	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		next_r.excl_fail = 1'b0;
		case (r.state)
			BBR_IDLE: begin
				if (core_req_in && core_excl_in && (alias_op || in_bitwin)) begin
					// Exclusives unsupported here: fail with no bus access
					next_r.done      = 1'b1;
					next_r.excl_fail = 1'b1;
					next_r.rdata     = BBR_ZERO32;
				end else if (core_req_in && alias_op) begin
					next_r.req      = 1'b1;
					next_r.write    = 1'b0;
					next_r.size     = BBR_SIZE_BYTE;
					next_r.addr     = tgt_byte;
					next_r.bit_num  = tgt_bit;
					next_r.new_bit  = core_wdata_in[0];
					next_r.is_alias = core_write_in;
					next_r.lock     = core_write_in;
					next_r.state    = BBR_RD;
				end else if (core_req_in) begin
					next_r.req      = 1'b1;
					next_r.write    = core_write_in;
					next_r.size     = core_size_in;
					next_r.addr     = core_addr_in;
					next_r.wdata    = core_wdata_in;
					next_r.lock     = 1'b0;
					next_r.state    = BBR_PASS;
				end
			end
			BBR_PASS: begin
				if (bus_done_in) begin
					next_r.req   = 1'b0;
					next_r.done  = 1'b1;
					next_r.rdata = bus_rdata_in;
					next_r.state = BBR_IDLE;
				end
			end
			BBR_RD: begin
				if (bus_done_in) begin
					if (r.is_alias) begin
						// Write back in the same locked sequence
						next_r.write = 1'b1;
						next_r.wdata = {4{mod_byte}};
						next_r.state = BBR_WR;
					end else begin
						next_r.req   = 1'b0;
						next_r.done  = 1'b1;
						next_r.rdata = {31'h0000_0000, rd_byte[r.bit_num]};
						next_r.state = BBR_IDLE;
					end
				end
			end
			BBR_WR: begin
				if (bus_done_in) begin
					next_r.req   = 1'b0;
					next_r.lock  = 1'b0;
					next_r.done  = 1'b1;
					next_r.rdata = BBR_ZERO32;
					next_r.state = BBR_IDLE;
				end
			end
			default: next_r.state = BBR_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign bus_req_out        = r.req;
	assign bus_write_out      = r.write;
	assign bus_lock_out       = r.lock;
	assign bus_size_out       = r.size;
	assign bus_addr_out       = r.addr;
	assign bus_wdata_out      = r.wdata;
	assign core_done_out      = r.done;
	assign core_excl_fail_out = r.excl_fail;
	assign core_rdata_out     = r.rdata;

	// ==========================================================
	// Checks
	a_rd_lsb_only: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(r.state == BBR_RD && bus_done_in && !r.is_alias) |=> (core_rdata_out[31:1] == 31'h0))
		else $error("alias read result has upper bits set");
	a_rmw_to_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(r.state == BBR_RD && bus_done_in && r.is_alias) |=> (bus_write_out && bus_lock_out))
		else $error("alias write did not follow with locked write");
	a_lock_held: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(r.state == BBR_WR) |-> bus_lock_out)
		else $error("bus lock dropped during write phase");
	a_byte_target: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(r.state == BBR_IDLE && core_req_in && alias_op && !core_excl_in)
		|=> (bus_size_out == BBR_SIZE_BYTE && bus_addr_out == $past(tgt_byte)))
		else $error("alias access not sent to target byte");
	a_pass_addr: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(r.state == BBR_IDLE && core_req_in && !alias_op && !core_excl_in)
		|=> (bus_addr_out == $past(core_addr_in) && !bus_lock_out))
		else $error("plain access was altered");
	a_fetch_plain: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(r.state == BBR_IDLE && core_req_in && core_instr_in && !core_excl_in)
		|=> (bus_req_out && bus_addr_out == $past(core_addr_in)
			&& bus_size_out == $past(core_size_in)))
		else $error("instruction fetch was remapped");
	a_wbit_taken: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(r.state == BBR_WR) |-> (bus_wdata_out[8 * r.addr[1:0] + r.bit_num] == r.new_bit))
		else $error("written bit does not match data bit 0");
	a_stall_busy: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(!core_ready_out) |-> bus_req_out)
		else $error("core stalled with no bus access in progress");

endmodule
`default_nettype wire

/* File: bbr_bus_model.sv */
// Behavioural system bus memory on the far side of the remapper.
// Assumes one access at a time, held until done; unwritten words read ~addr.
`timescale 1ns/1ps
`default_nettype none
module bbr_bus_model (
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	input  wire logic        req_in,
	input  wire logic        write_in,
	input  wire logic [1:0]  size_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] wdata_in,
	output logic             done_out,
	output logic [31:0]      rdata_out
);
	logic [31:0] mem [logic [29:0]];
	logic [31:0] m;
	int          wait_n;
	function automatic logic [31:0] peek(input logic [29:0] a);
		return mem.exists(a) ? mem[a] : ~{a, 2'h0};
	endfunction
	// ==========================================================
	// Answer after 0..3 waits; stale data toggles so it never looks valid
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			done_out <= 1'b0;
			rdata_out <= 32'h0;
			wait_n <= 0;
		end else if (req_in && !done_out && wait_n == 0) begin
			done_out <= 1'b1;
			wait_n <= $urandom_range(3, 0);
			m = peek(addr_in[31:2]);
			if (!write_in) begin
				rdata_out <= m;
			end else begin
				for (int l = 0; l < 4; l++) begin
					if (size_in == 2'h2 || (size_in == 2'h1 && l[1] == addr_in[1]) ||
					    l[1:0] == addr_in[1:0]) begin
						m[8*l +: 8] = wdata_in[8*l +: 8];
					end
				end
				mem[addr_in[31:2]] = m;
			end
		end else begin
			done_out <= 1'b0;
			rdata_out <= ~rdata_out;
			if (req_in && wait_n > 0) wait_n <= wait_n - 1;
		end
	end
endmodule
`default_nettype wire

/* File: bbr_remap_tb.sv */
// Self-checking bench: random bit traffic through both alias windows.
// Assumes bbr_bus_model answers the system bus side.
`timescale 1ns/1ps
`default_nettype none
module bbr_remap_tb;
	import bbr_pkg::*;
	logic        clock_in = 1'b0, reset_n_in = 1'b0;
	logic        req = 1'b0, wr = 1'b0, ins = 1'b0, una = 1'b0, exc = 1'b0;
	logic [1:0]  sz = BBR_SIZE_WORD;
	logic [31:0] ad = BBR_ZERO32, wd = BBR_ZERO32;
	logic        rdy, dn, xf, b_req, b_wr, b_lk, b_dn;
	logic [1:0]  b_sz;
	logic [31:0] rd, b_ad, b_wd, b_rd;
	int          error_cnt = 0, n_checks = 0;
	always #5 clock_in = ~clock_in;
	bbr_remap bbr_remap_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .core_req_in(req),
		.core_write_in(wr), .core_instr_in(ins), .core_unaligned_in(una), .core_excl_in(exc),
		.core_size_in(sz), .core_addr_in(ad), .core_wdata_in(wd), .core_ready_out(rdy),
		.core_done_out(dn), .core_excl_fail_out(xf), .core_rdata_out(rd), .bus_req_out(b_req),
		.bus_write_out(b_wr), .bus_lock_out(b_lk), .bus_size_out(b_sz), .bus_addr_out(b_ad),
		.bus_wdata_out(b_wd), .bus_done_in(b_dn), .bus_rdata_in(b_rd));
	bbr_bus_model bbr_bus_model_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .req_in(b_req),
		.write_in(b_wr), .size_in(b_sz), .addr_in(b_ad), .wdata_in(b_wd), .done_out(b_dn),
		.rdata_out(b_rd));
	// ==========================================================
	// Helpers
	task end_sim;
		$display("Checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task chk_bit(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Request held until taken, then lines inverted so stale values never match
	task automatic acc(input logic w, i, u, x, input logic [1:0] s, input logic [31:0] a, d,
		output logic [31:0] r, output logic f);
		int n;
		@(posedge clock_in);
		{req, wr, ins, una, exc, sz, ad, wd} <= {1'b1, w, i, u, x, s, a, d};
		n = 0;
		do begin @(posedge clock_in); n++; end while (rdy !== 1'b1 && n < 50);
		if (rdy !== 1'b1) error_cnt++;
		req <= 1'b0;
		ad <= ~a;
		wd <= ~d;
		n = 0;
		do begin @(negedge clock_in); n++; end while (dn !== 1'b1 && n < 50);
		if (dn !== 1'b1) error_cnt++;
		r = rd;
		f = xf;
	endtask
	function automatic logic [31:0] aa(input logic p, input logic [19:0] o, input logic [2:0] b);
		return (p ? BBR_PERI_ALIAS_BASE : BBR_SRAM_ALIAS_BASE) + {7'h00, o, b, 2'h0};
	endfunction
	// ==========================================================
	// Main sequence; first four passes hit the window corners
	initial begin
		logic [31:0] r, d, e, ta, al;
		logic        f, p;
		logic [19:0] o;
		logic [2:0]  b;
		int          bi;
		r = $urandom(32'hCADF);
		repeat (12) @(posedge clock_in);
		reset_n_in <= 1'b1;
		for (int k = 0; k < 40; k++) begin
			p = k[0];
			o = (k < 2) ? 20'h00000 : (k < 4) ? 20'hFFFFF : 20'($urandom);
			b = (k < 4) ? {3{k[1]}} : 3'($urandom);
			ta = (p ? BBR_PERI_BIT_BASE : BBR_SRAM_BIT_BASE) + {12'h000, o[19:2], 2'h0};
			al = aa(p, o, b);
			bi = {o[1:0], b};
			d = $urandom;
			acc(1'b1, 1'b0, 1'b0, 1'b0, BBR_SIZE_WORD, ta, d, r, f);
			acc(1'b0, 1'b0, 1'b0, 1'b0, BBR_SIZE_WORD, al, $urandom, r, f);
			chk(r, {31'h0, d[bi]});
			e = $urandom;
			acc(1'b1, 1'b0, 1'b0, 1'b0, BBR_SIZE_WORD, al, e, r, f);
			d[bi] = e[0];
			acc(1'b0, 1'b0, 1'b0, 1'b0, BBR_SIZE_WORD, ta, 32'h0, r, f);
			chk(r, d);
			acc(1'b0, 1'b1, 1'b0, 1'b0, BBR_SIZE_WORD, al, 32'h0, r, f);
			chk(r, ~al);
			acc(1'b0, 1'b0, 1'b1, 1'b0, BBR_SIZE_WORD, al, 32'h0, r, f);
			chk(r, ~al);
			acc(1'b0, 1'b0, 1'b0, 1'b1, BBR_SIZE_WORD, p ? al : ta, 32'h0, r, f);
			chk_bit(f, 1'b1);
		end
		acc(1'b0, 1'b0, 1'b0, 1'b1, BBR_SIZE_WORD, 32'h6000_0000, 32'h0, r, f);
		chk_bit(f, 1'b0);
		chk(r, ~32'h6000_0000);
		end_sim();
	end
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule
`default_nettype wire
